// ---- inc/overcurrent_guard_cfg.svh ----
// Timing and count constants for the overcurrent hiccup sequencer.
// Assumes a 50 MHz system clock; the discharge count is in clk_sys cycles, the trip count in switching cycles.
`ifndef OVERCURRENT_GUARD_CFG_SVH
`define OVERCURRENT_GUARD_CFG_SVH

`define OCG_TRIP_COUNT      2'h2
`define OCG_DISCHARGE_CYCLES 9'h100
`define OCG_SS_WIDTH        24

`endif

// ---- inc/overcurrent_guard_pkg.sv ----
// Types for the overcurrent hiccup sequencer.
// Assumes nothing beyond the cfg header.
package overcurrent_guard_pkg;
	typedef enum logic [2:0] {
		ST_IDLE      = 3'h0,
		ST_DISCHARGE = 3'h1,
		ST_SOFTSTART = 3'h2,
		ST_RUN       = 3'h3,
		ST_WAIT      = 3'h4
	} guard_state_e;
endpackage

// ---- design/overcurrent_guard.sv ----
// Overcurrent hiccup sequencer: counts over-threshold switching cycles, shuts the
// power stage down, waits one soft-start length and restarts.
// Assumes cycleTick marks one switching cycle and comparator inputs are valid then.
`include "overcurrent_guard_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module overcurrent_guard
	import overcurrent_guard_pkg::*;
(
	input  wire logic                    clk_sys,
	input  wire logic                    rst_n,
	input  wire logic                    enable,
	input  wire logic                    powerOnOk,
	input  wire logic                    cycleTick,
	input  wire logic                    senseOverA,
	input  wire logic                    senseOverB,
	input  wire logic [`OCG_SS_WIDTH-1:0] softStartCycles,
	output logic                         switchEnable,
	output logic                         rampDischarge,
	output logic                         rampRun,
	output logic                         regulation_ok_flag,
	output logic                         overcurrent_event
);

	guard_state_e            state_q, state_d;
	logic [1:0]              ocCount_q, ocCount_d;
	logic [`OCG_SS_WIDTH-1:0] timer_q, timer_d;

	wire supplyOk   = enable & powerOnOk;
	wire sampleOver = senseOverA & senseOverB;
	wire sampleHit  = cycleTick & sampleOver;
	wire sampleLow  = cycleTick & ~sampleOver;
	wire activeSt   = (state_q == ST_SOFTSTART) || (state_q == ST_RUN);
	// Two-bit count is enough: the trip at two clears it before it could wrap
	wire [1:0] countInc = ocCount_q + 2'h1;
	wire tripNow    = activeSt & sampleHit & (countInc == `OCG_TRIP_COUNT);
	wire timerDone  = (timer_q == '0);
	wire [`OCG_SS_WIDTH-1:0] timerDec = timer_q - 1'b1;
	wire [`OCG_SS_WIDTH-1:0] dischargeLoad = `OCG_SS_WIDTH'(`OCG_DISCHARGE_CYCLES - 9'h1);
	wire [`OCG_SS_WIDTH-1:0] ssLoad = (softStartCycles == '0) ? '0 : softStartCycles - 1'b1;

	always_comb begin
		state_d   = state_q;
		ocCount_d = ocCount_q;
		timer_d   = timerDone ? timer_q : timerDec;
		case (state_q)
			ST_IDLE: begin
				ocCount_d = 2'h0;
				if (supplyOk) begin
					state_d = ST_SOFTSTART;
					timer_d = ssLoad;
				end
			end
			ST_DISCHARGE: begin
				ocCount_d = 2'h0;
				if (timerDone)
					state_d = ST_IDLE;
			end
			ST_SOFTSTART, ST_RUN: begin
				if (tripNow) begin
					state_d   = ST_WAIT;
					ocCount_d = 2'h0;
					timer_d   = ssLoad;
				end else begin
					if (sampleHit)
						ocCount_d = countInc;
					else if (sampleLow)
						ocCount_d = 2'h0;
					if (state_q == ST_SOFTSTART && timerDone)
						state_d = ST_RUN;
				end
			end
			ST_WAIT: begin
				ocCount_d = 2'h0;
				if (timerDone) begin
					state_d = ST_SOFTSTART;
					timer_d = ssLoad;
				end
			end
			default: begin
				state_d   = ST_IDLE;
				ocCount_d = 2'h0;
			end
		endcase
		if (!supplyOk && state_q != ST_IDLE && state_q != ST_DISCHARGE) begin
			state_d   = ST_DISCHARGE;
			ocCount_d = 2'h0;
			timer_d   = dischargeLoad;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= ST_IDLE;
			ocCount_q <= 2'h0;
			timer_q   <= '0;
		end else begin
			state_q   <= state_d;
			ocCount_q <= ocCount_d;
			timer_q   <= timer_d;
		end
	end

	// Outputs registered from the next state, overcurrent_event from tripNow, so they change with the state itself
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			switchEnable       <= 1'b0;
			rampDischarge      <= 1'b0;
			rampRun            <= 1'b0;
			regulation_ok_flag <= 1'b0;
			overcurrent_event  <= 1'b0;
		end else begin
			switchEnable       <= (state_d == ST_SOFTSTART) || (state_d == ST_RUN);
			rampDischarge      <= (state_d == ST_DISCHARGE);
			rampRun            <= (state_d == ST_SOFTSTART);
			regulation_ok_flag <= (state_d == ST_RUN) && enable;
			overcurrent_event  <= tripNow;
		end
	end

	// Trip path
	a_trip_shutdown: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(tripNow && supplyOk)
		|=> (state_q == ST_WAIT) && !switchEnable && ocCount_q == 2'h0)
		else $error("trip did not shut down into wait");

	a_single_hit: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(activeSt && supplyOk && sampleHit && ocCount_q == 2'h0)
		|=> state_q != ST_WAIT)
		else $error("single sample caused a trip");

	a_both_needed: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(activeSt && supplyOk && cycleTick && !(senseOverA && senseOverB))
		|=> ocCount_q == 2'h0)
		else $error("counter kept without agreement");

	a_one_comparator: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(activeSt && supplyOk && cycleTick && (senseOverA ^ senseOverB))
		|=> ocCount_q == 2'h0 && state_q != ST_WAIT)
		else $error("single comparator counted as overcurrent");

	a_count_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(activeSt && supplyOk && !cycleTick)
		|=> $stable(ocCount_q))
		else $error("counter moved without a cycle tick");

	a_count_up: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(activeSt && supplyOk && sampleHit && ocCount_q == 2'h0)
		|=> ocCount_q == 2'h1)
		else $error("counter did not advance on a hit");

	a_event_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
		overcurrent_event
		|=> !overcurrent_event)
		else $error("trip event longer than one cycle");

	// Hiccup wait and restart
	a_wait_dark: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_WAIT)
		|-> !switchEnable && !regulation_ok_flag)
		else $error("switches on while waiting");

	a_wait_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_WAIT)
		|-> ocCount_q == 2'h0)
		else $error("counter not clear while waiting");

	a_wait_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_WAIT && !timerDone && supplyOk)
		|=> state_q == ST_WAIT)
		else $error("wait ended before the soft-start length");

	a_wait_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_WAIT && timerDone && supplyOk)
		|=> state_q == ST_SOFTSTART && rampRun)
		else $error("no restart after wait");

	a_retry_again: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_SOFTSTART && tripNow && supplyOk)
		|=> state_q == ST_WAIT)
		else $error("restart trip did not start a new hiccup");

	a_ss_to_run: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_SOFTSTART && timerDone && supplyOk && !tripNow)
		|=> regulation_ok_flag)
		else $error("regulation ok not raised after soft-start");

	a_run_switch: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_RUN)
		|-> switchEnable && !rampRun)
		else $error("switches off while running");

	// Supply loss
	a_enable_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(enable)
		|=> !regulation_ok_flag)
		else $error("regulation ok stayed high after enable fell");

	a_discharge_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q != ST_DISCHARGE && state_q != ST_IDLE && !supplyOk)
		|=> (rampDischarge [*8]))
		else $error("discharge shorter than expected");

	a_idle_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_IDLE || state_q == ST_DISCHARGE)
		|-> ocCount_q == 2'h0 && !switchEnable)
		else $error("counter or switches active in idle or discharge");

	a_discharge_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_DISCHARGE && timerDone)
		|=> state_q == ST_IDLE)
		else $error("discharge did not return to idle");

endmodule

`default_nettype wire

// ---- verif/sense_model.sv ----
// Comparator and switching-cycle model for the overcurrent sequencer.
// Assumes one clock; comparator outputs mean something only on cycleTick.
`timescale 1ns/1ns
`default_nettype none
module sense_model (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic overA,
	input  wire logic overB,
	output logic      cycleTick,
	output logic      senseOverA,
	output logic      senseOverB
);
	logic [1:0] phase_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) phase_q <= 2'h0;
		else phase_q <= phase_q + 2'h1;
	end
	assign cycleTick = (phase_q == 2'h3);
	// Off the sample the outputs are not valid, so show the inverse to expose stray sampling
	assign senseOverA = cycleTick ? overA : ~overA;
	assign senseOverB = cycleTick ? overB : ~overB;
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the overcurrent hiccup sequencer.
// Assumes the comparator model in sense_model.sv and a 50 MHz clock.
`include "overcurrent_guard_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam int N = 32;
	logic clk_sys = 0, rst_n = 0, enable = 0, powerOnOk = 0, overA = 0, overB = 0;
	logic cycleTick, senseOverA, senseOverB, switchEnable, rampDischarge, rampRun;
	logic regulation_ok_flag, overcurrent_event;
	int   error_cnt = 0, checks = 0, evCnt = 0, n;
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (overcurrent_event === 1'b1) evCnt++;
	sense_model i_sense_model (.clk_sys(clk_sys), .rst_n(rst_n), .overA(overA), .overB(overB),
		.cycleTick(cycleTick), .senseOverA(senseOverA), .senseOverB(senseOverB));
	overcurrent_guard i_overcurrent_guard (.clk_sys(clk_sys), .rst_n(rst_n), .enable(enable),
		.powerOnOk(powerOnOk), .cycleTick(cycleTick), .senseOverA(senseOverA),
		.senseOverB(senseOverB), .softStartCycles(`OCG_SS_WIDTH'(N)),
		.switchEnable(switchEnable), .rampDischarge(rampDischarge), .rampRun(rampRun),
		.regulation_ok_flag(regulation_ok_flag), .overcurrent_event(overcurrent_event));
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %0h seen %0h", w, e, g);
		end
	endtask
	task automatic finish_test;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic fail_timeout(input string w);
		error_cnt++;
		$display("CHECK FAILED %s expected done seen timeout", w);
		finish_test();
	endtask
	// Counts cycles from the edge after the one that launched the level
	task automatic span(input int sel);
		n = 0;
		do begin @(posedge clk_sys); #1; n++; end
		while ((sel == 0 ? rampRun : sel == 1 ? rampDischarge : !switchEnable) === 1'b1 && n < 400);
		if (n >= 400) fail_timeout("level span");
	endtask
	// Returns in the edge that samples the tick, before the design's answer lands
	task automatic tick(input logic a, input logic b);
		int k;
		@(posedge clk_sys);
		overA <= a;
		overB <= b;
		k = 0;
		do begin @(posedge clk_sys); k++; end while (cycleTick !== 1'b1 && k < 8);
		if (cycleTick !== 1'b1) fail_timeout("cycle tick");
	endtask
	task automatic soft_start;
		int k;
		@(posedge clk_sys);
		overA <= 1'b0;
		overB <= 1'b0;
		#1;
		k = 0;
		while (rampRun !== 1'b1 && k < 100) begin
			@(posedge clk_sys);
			#1;
			k++;
		end
		if (rampRun !== 1'b1) fail_timeout("ramp start");
		chk("switch on", 1, switchEnable);
		span(0);
		chk("ramp len", N, n);
		chk("reg ok", 1, regulation_ok_flag);
	endtask
	task automatic run_first_trip;
		tick(1, 1);
		tick(1, 0);
		tick(1, 1);
		chk("event count", 0, evCnt);
		tick(1, 1);
		#1;
		chk("event", 1, overcurrent_event);
		chk("switch off", 0, switchEnable);
		chk("reg ok", 0, regulation_ok_flag);
		span(2);
		chk("wait len", N, n);
		chk("restart", 1, rampRun);
	endtask
	task automatic run_retry;
		tick(1, 1);
		tick(0, 0);
		chk("event count", 1, evCnt);
		tick(1, 1);
		tick(1, 1);
		@(posedge clk_sys);
		#1;
		chk("event count", 2, evCnt);
		chk("switch off", 0, switchEnable);
		soft_start();
	endtask
	task automatic run_disable;
		@(posedge clk_sys);
		enable <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk("reg ok", 0, regulation_ok_flag);
		span(1);
		chk("discharge len", 256, n);
		chk("idle", 0, switchEnable | rampRun);
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		enable <= 1'b1;
		powerOnOk <= 1'b1;
		soft_start();
		run_first_trip();
		run_retry();
		run_disable();
		finish_test();
	end
endmodule
`default_nettype wire
